// file: logic/kde_editor.sv
// digit-by-digit parameter value editor behind keypad and seven-segment display
`timescale 1ns/10ps
module kde_editor #(
  parameter int HOLD_CNT = kde_pkg::HOLD_CYCLES,
  parameter int LIMIT_CNT = kde_pkg::LIMIT_CYCLES,
  parameter int ERR_CNT = kde_pkg::ERR_CYCLES,
  parameter int DEBOUNCE_CNT = kde_pkg::DEBOUNCE_CYCLES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // keypad
  input wire kde_pkg::kde_keys_t keys_in,
  // parameter under edit
  input wire logic edit_active_in,
  input wire logic load_in,
  input wire kde_pkg::kde_param_t param_in,
  // results
  output logic commit_out,
  output kde_pkg::kde_val_t commit_value_out,
  output logic nav_up_out,
  output logic nav_down_out,
  output logic mode_short_out,
  output logic cursor_mode_out,
  output logic error_out,
  // display
  output kde_pkg::kde_disp_t disp_out
);
  import kde_pkg::*;

  typedef struct packed {
    kde_state_t st;
    logic cur_on;
    logic [2:0] cursor;
    logic neg;
    kde_digits_t dig;
    logic [31:0] hold_cnt;
    logic fired;
    logic mode_prev;
    logic [31:0] tmr;
    logic lim_neg;
    kde_digits_t lim_dig;
    logic commit;
    kde_val_t commit_val;
    logic nav_up;
    logic nav_dn;
    logic mode_short;
    kde_disp_t disp;
  } kde_core_t;

  kde_core_t s;
  kde_core_t next_s;

  logic [3:0] key_lvl;
  logic [3:0] key_prs;
  kde_keys_t kl;
  kde_keys_t kp;

  // ==========================================================
  // key filters
  for (genvar k = 0; k < 4; k++)
  begin : g_key
    kde_debounce #(
      .COUNT(DEBOUNCE_CNT)
    ) u_deb (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .key_in(keys_in[k]),
      .level_out(key_lvl[k]),
      .press_out(key_prs[k])
    );
  end

  assign kl = kde_keys_t'(key_lvl);
  assign kp = kde_keys_t'(key_prs);

  // ==========================================================
  // helpers
  function automatic kde_digits_t to_bcd(input logic [16:0] mag);
    kde_digits_t d;
    logic [16:0] m;
    m = mag;
    for (int i = 0; i < NDIG; i++)
    begin
      d[i] = 4'(m % 17'd10);
      m = m / 17'd10;
    end
    return d;
  endfunction

  function automatic logic [16:0] from_bcd(input kde_digits_t d);
    logic [16:0] v;
    v = '0;
    for (int i = NDIG - 1; i >= 0; i--)
      v = 17'(v * 17'd10 + 17'(d[i]));
    return v;
  endfunction

  function automatic kde_val_t sval(input logic neg, input kde_digits_t d);
    kde_val_t m;
    m = kde_val_t'({1'b0, from_bcd(d)});
    return neg ? -m : m;
  endfunction

  function automatic logic [16:0] mag_of(input kde_val_t v);
    kde_val_t a;
    a = (v < 0) ? -v : v;
    return a[16:0];
  endfunction

  // unsupported characters return a dark pattern
  function automatic logic [6:0] seg_of(input logic [7:0] ch);
    logic [6:0] p;
    unique case (ch)
      8'h30: p = 7'h3f;
      8'h31: p = 7'h06;
      8'h32: p = 7'h5b;
      8'h33: p = 7'h4f;
      8'h34: p = 7'h66;
      8'h35: p = 7'h6d;
      8'h36: p = 7'h7d;
      8'h37: p = 7'h07;
      8'h38: p = 7'h7f;
      8'h39: p = 7'h6f;
      8'h41: p = 7'h77;
      8'h62: p = 7'h7c;
      8'h43: p = 7'h39;
      8'h63: p = 7'h58;
      8'h64: p = 7'h5e;
      8'h45: p = 7'h79;
      8'h46: p = 7'h71;
      8'h48: p = 7'h76;
      8'h68: p = 7'h74;
      8'h4c: p = 7'h38;
      8'h6e: p = 7'h54;
      8'h6f: p = 7'h5c;
      8'h50: p = 7'h73;
      8'h71: p = 7'h67;
      8'h72: p = 7'h50;
      8'h53: p = 7'h6d;
      8'h74: p = 7'h78;
      8'h55: p = 7'h3e;
      8'h75: p = 7'h1c;
      8'h79: p = 7'h6e;
      8'h2d: p = 7'h40;
      default: p = 7'h00;
    endcase
    return p;
  endfunction

  function automatic kde_disp_t render(input logic neg, input kde_digits_t dig,
                                       input logic [1:0] dec, input logic sgn,
                                       input logic cur_on, input logic [2:0] cursor);
    kde_disp_t d;
    logic shift;
    d = '0;
    // large two-decimal signed values drop the hundredths digit
    shift = sgn && (dec == 2'd2) && (from_bcd(dig) > 17'(TWO_DEC_MAG));
    if (shift)
    begin
      d.seg[4] = neg ? seg_of(CH_MINUS) : 7'h00;
      for (int i = 0; i < NDIG - 1; i++)
        d.seg[i] = seg_of({CH_DIGIT_HI, dig[i+1]});
      d.dp[SHIFT_DP_POS] = 1'b1;
      // the hidden hundredths digit cannot blink
      if (cur_on && cursor != 3'd0)
        d.blink[cursor - 3'd1] = 1'b1;
    end
    else
    begin
      d.seg[5] = neg ? seg_of(CH_MINUS) : 7'h00;
      for (int i = 0; i < NDIG; i++)
        d.seg[i] = seg_of({CH_DIGIT_HI, dig[i]});
      if (dec != 2'd0)
        d.dp[dec] = 1'b1;
      if (cur_on)
        d.blink[cursor] = 1'b1;
    end
    return d;
  endfunction

  function automatic kde_val_t clamp_step(input kde_val_t v, input logic up, input logic sgn);
    kde_val_t r;
    r = up ? v + 18'sd1 : v - 18'sd1;
    if (r > kde_val_t'(MAX_MAG))
      r = kde_val_t'(MAX_MAG);
    if (r < (sgn ? -kde_val_t'(MAX_MAG) : 18'sd0))
      r = sgn ? -kde_val_t'(MAX_MAG) : 18'sd0;
    return r;
  endfunction

  // ==========================================================
  // editor
  kde_val_t cur_val;
  kde_val_t step_val;

  always_comb
  begin
    cur_val = sval(s.neg, s.dig);
    step_val = cur_val;
    next_s = s;
    next_s.commit = 1'b0;
    next_s.nav_up = 1'b0;
    next_s.nav_dn = 1'b0;
    next_s.mode_short = 1'b0;
    next_s.mode_prev = kl.mode;

    // mode hold: toggles once per hold, a short press is passed on at release
    if (kl.mode)
    begin
      if (s.hold_cnt != 32'(HOLD_CNT))
        next_s.hold_cnt = s.hold_cnt + 32'h0000_0001;
      else if (!s.fired)
      begin
        next_s.fired = 1'b1;
        next_s.cur_on = !s.cur_on;
        next_s.cursor = '0;
      end
    end
    else
    begin
      next_s.hold_cnt = '0;
      next_s.fired = 1'b0;
      if (s.mode_prev && !s.fired)
        next_s.mode_short = 1'b1;
    end

    unique case (s.st)
      KDE_EDIT:
      begin
        if (load_in)
        begin
          next_s.neg = param_in.value < 0;
          next_s.dig = to_bcd(mag_of(param_in.value));
          next_s.cursor = '0;
        end
        else if (!edit_active_in)
        begin
          // navigation keys never see the digit cursor
          next_s.nav_up = kp.up;
          next_s.nav_dn = kp.down;
        end
        else if (kp.enter)
        begin
          if (cur_val > param_in.max)
          begin
            next_s.st = KDE_ERR;
            next_s.tmr = '0;
            next_s.lim_neg = param_in.max < 0;
            next_s.lim_dig = to_bcd(mag_of(param_in.max));
          end
          else if (cur_val < param_in.min)
          begin
            next_s.st = KDE_ERR;
            next_s.tmr = '0;
            next_s.lim_neg = param_in.min < 0;
            next_s.lim_dig = to_bcd(mag_of(param_in.min));
          end
          else
          begin
            // cursor mode is left as it is
            next_s.commit = 1'b1;
            next_s.commit_val = cur_val;
          end
        end
        else if (kp.up)
        begin
          if (!s.cur_on)
          begin
            step_val = clamp_step(cur_val, 1'b1, param_in.is_signed);
            next_s.neg = step_val < 0;
            next_s.dig = to_bcd(mag_of(step_val));
          end
          else if (s.cursor == 3'(LEFT_DIG) && param_in.is_signed && s.dig[LEFT_DIG] == 4'h0)
          begin
            // leftmost zero goes to minus, minus goes on to one
            next_s.neg = !s.neg;
            if (s.neg)
              next_s.dig[LEFT_DIG] = 4'h1;
          end
          else
          begin
            next_s.dig[s.cursor] = (s.dig[s.cursor] == 4'h9) ? 4'h0
                                   : s.dig[s.cursor] + 4'h1;
          end
        end
        else if (kp.down)
        begin
          if (!s.cur_on)
          begin
            step_val = clamp_step(cur_val, 1'b0, param_in.is_signed);
            next_s.neg = step_val < 0;
            next_s.dig = to_bcd(mag_of(step_val));
          end
          else
          begin
            next_s.cursor = (s.cursor == 3'(LEFT_DIG)) ? 3'd0
                            : s.cursor + 3'd1;
          end
        end
      end
      KDE_ERR:
      begin
        if (s.tmr >= 32'(ERR_CNT - 1))
        begin
          next_s.st = KDE_LIMIT;
          next_s.tmr = '0;
        end
        else
          next_s.tmr = s.tmr + 32'h0000_0001;
      end
      KDE_LIMIT:
      begin
        if (s.tmr >= 32'(LIMIT_CNT - 1))
        begin
          // the stored value was never replaced, so reload it
          next_s.st = KDE_EDIT;
          next_s.tmr = '0;
          next_s.neg = param_in.value < 0;
          next_s.dig = to_bcd(mag_of(param_in.value));
          next_s.cursor = '0;
        end
        else
          next_s.tmr = s.tmr + 32'h0000_0001;
      end
    endcase

    if (next_s.st == KDE_ERR)
    begin
      next_s.disp = '0;
      next_s.disp.seg[2] = seg_of(CH_E);
      next_s.disp.seg[1] = seg_of(CH_R);
      next_s.disp.seg[0] = seg_of(CH_R);
    end
    else if (next_s.st == KDE_LIMIT)
      next_s.disp = render(next_s.lim_neg, next_s.lim_dig, param_in.decimals,
                           param_in.is_signed, 1'b0, 3'd0);
    else
      next_s.disp = render(next_s.neg, next_s.dig, param_in.decimals,
                           param_in.is_signed, next_s.cur_on, next_s.cursor);
  end

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      s <= '0;
      s.st <= KDE_EDIT;
    end
    else
      s <= next_s;
  end

  // ==========================================================
  // outputs
  assign commit_out = s.commit;
  assign commit_value_out = s.commit_val;
  assign nav_up_out = s.nav_up;
  assign nav_down_out = s.nav_dn;
  assign mode_short_out = s.mode_short;
  assign cursor_mode_out = s.cur_on;
  assign error_out = (s.st != KDE_EDIT);
  assign disp_out = s.disp;
endmodule

// file: logic/kde_pkg.sv
// constants, types and timing for the keypad digit entry editor
// What this block does
// - mode key held over two seconds toggles digit cursor; on shows rightmost blinking
// - digit cursor acts only while changing a value, not on parameter navigation
// - cursor off: up and left/down step the whole value
// - cursor on: up increments only the blinking digit, nine wraps to zero
// - cursor on: left/down moves the blinking position one digit left
// - cursor stays on after a confirmed value; only a long press turns it off
// - signed: leftmost digit at zero turns into a minus sign on up
// - out of range enter shows the error, then the violated limit for one second
// - rejected entry leaves the stored parameter value untouched
// - rejected entry puts the cursor back on the rightmost digit
// - frequency example: above 599.00 is rejected and 599.00 is shown
// - signed one decimal example: beyond 100.0 or -100.0 rejected, limit shown
// - two decimal signed values beyond 99.99 display with one decimal
// - two decimal signed -100.0 stepped up displays -99.99
// - digits, the minus sign and a fixed letter subset map to segments; others stay dark
// - left/down decrements normally and moves the cursor in cursor mode
package kde_pkg;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 250_000_000;
  localparam int HOLD_TIME_MS = 2000;
  localparam int LIMIT_TIME_MS = 1000;
  localparam int ERR_TIME_MS = 500;
  localparam int DEBOUNCE_TIME_MS = 10;
  localparam int HOLD_CYCLES = CLK_HZ / 1000 * HOLD_TIME_MS;
  localparam int LIMIT_CYCLES = CLK_HZ / 1000 * LIMIT_TIME_MS;
  localparam int ERR_CYCLES = CLK_HZ / 1000 * ERR_TIME_MS;
  localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_TIME_MS;

  // ==========================================================
  // value format: five decimal digits plus sign, in least-step units
  localparam int NDIG = 5;
  localparam int LEFT_DIG = 4;
  localparam int MAX_MAG = 99999;
  localparam int TWO_DEC_MAG = 9999;
  localparam int SHIFT_DP_POS = 1;

  // example parameters, in least-step units
  localparam int FREQ_MAX = 59900;
  localparam int FREQ_DEFAULT = 6000;
  localparam int S1_MAX = 1000;
  localparam int S1_MIN = -1000;
  localparam int S1_DEFAULT = 0;
  localparam int S2_MAX = 10000;
  localparam int S2_MIN = -10000;
  localparam int S2_DEFAULT = -10000;

  // ==========================================================
  // character codes (ascii)
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_R = 8'h72;
  localparam logic [3:0] CH_DIGIT_HI = 4'h3;

  // ==========================================================
  // types
  typedef logic signed [17:0] kde_val_t;
  typedef logic [NDIG-1:0][3:0] kde_digits_t;

  typedef struct packed {
    kde_val_t value;
    kde_val_t min;
    kde_val_t max;
    logic is_signed;
    logic [1:0] decimals;
  } kde_param_t;

  typedef struct packed {
    logic up;
    logic down;
    logic mode;
    logic enter;
  } kde_keys_t;

  // segments gfedcba, position 5 leftmost
  typedef struct packed {
    logic [5:0][6:0] seg;
    logic [5:0] dp;
    logic [5:0] blink;
  } kde_disp_t;

  typedef enum logic [2:0] {
    KDE_EDIT = 3'b001,
    KDE_ERR = 3'b010,
    KDE_LIMIT = 3'b100
  } kde_state_t;

endpackage

// file: logic/kde_debounce.sv
// key synchroniser and debouncer with one-cycle press pulse
`timescale 1ns/10ps
module kde_debounce #(
  parameter int COUNT = kde_pkg::DEBOUNCE_CYCLES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // raw key
  input wire logic key_in,
  // filtered key
  output logic level_out,
  output logic press_out
);
  import kde_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic level;
    logic press;
    logic [31:0] cnt;
  } kde_deb_t;

  kde_deb_t s;
  kde_deb_t next_s;

  // ==========================================================
  // filter
  always_comb
  begin
    next_s = s;
    next_s.sync1 = key_in;
    next_s.sync2 = s.sync1;
    next_s.press = 1'b0;
    if (s.sync2 == s.level)
    begin
      next_s.cnt = '0;
    end
    else if (s.cnt >= 32'(COUNT - 1))
    begin
      // level must differ for COUNT cycles before it is believed
      next_s.level = s.sync2;
      next_s.cnt = '0;
      next_s.press = s.sync2;
    end
    else
    begin
      next_s.cnt = s.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      s <= '0;
    else
      s <= next_s;
  end

  assign level_out = s.level;
  assign press_out = s.press;
endmodule

// file: testbench/kde_editor_props.sv
// port assertions for the keypad digit entry editor
`timescale 1ns/10ps
module kde_editor_props
  import kde_pkg::*;
#(
  parameter int HOLD_CNT = 8,
  parameter int LIMIT_CNT = 6,
  parameter int ERR_CNT = 4,
  parameter int DEBOUNCE_CNT = 2
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // watched ports
  input wire kde_pkg::kde_keys_t keys_in,
  input wire logic edit_active_in,
  input wire logic commit_out,
  input wire kde_pkg::kde_val_t commit_value_out,
  input wire logic nav_up_out,
  input wire logic nav_down_out,
  input wire logic cursor_mode_out,
  input wire logic error_out,
  input wire kde_pkg::kde_disp_t disp_out
);
  // ==========
  // helper: length of the current error episode
  logic [7:0] err_cnt;
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      err_cnt <= 8'h00;
    else
      err_cnt <= error_out ? err_cnt + 8'h01 : 8'h00;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  commit_pulse_a: assert property (commit_out |=> !commit_out)
    else $error("commit pulse too long");
  no_commit_err_a: assert property (error_out |-> !commit_out)
    else $error("commit during error");
  err_length_a: assert property ($fell(error_out) |-> err_cnt == ERR_CNT + LIMIT_CNT)
    else $error("error episode length wrong");
  err_bound_a: assert property (err_cnt <= ERR_CNT + LIMIT_CNT)
    else $error("error episode too long");
  commit_hold_a: assert property (!commit_out |-> $stable(commit_value_out))
    else $error("committed value moved");
  nav_idle_a: assert property ((nav_up_out || nav_down_out) |-> !$past(edit_active_in))
    else $error("navigation while editing");
  nav_pulse_a: assert property (nav_down_out |=> !nav_down_out)
    else $error("navigation pulse too long");
  blink_on_a: assert property ($rose(cursor_mode_out) |-> (disp_out.blink & 6'h3e) == 6'h00)
    else $error("cursor not at rightmost");
  blink_off_a: assert property (!cursor_mode_out |-> disp_out.blink == 6'h00)
    else $error("blink without cursor mode");
  toggle_cause_a: assert property ($changed(cursor_mode_out) |-> $past(keys_in.mode, HOLD_CNT))
    else $error("cursor toggled without long press");
  cover property (commit_out);
  cover property ($rose(error_out));
  cover property ($rose(cursor_mode_out));
  cover property (nav_up_out);
endmodule

bind kde_editor kde_editor_props #(
  .HOLD_CNT(HOLD_CNT),
  .LIMIT_CNT(LIMIT_CNT),
  .ERR_CNT(ERR_CNT),
  .DEBOUNCE_CNT(DEBOUNCE_CNT)
) props (
  .clock_in(clock_in),
  .nrst_in(nrst_in),
  .keys_in(keys_in),
  .edit_active_in(edit_active_in),
  .commit_out(commit_out),
  .commit_value_out(commit_value_out),
  .nav_up_out(nav_up_out),
  .nav_down_out(nav_down_out),
  .cursor_mode_out(cursor_mode_out),
  .error_out(error_out),
  .disp_out(disp_out)
);

// file: testbench/kde_operator.sv
// keypad operator model: presses and holds keys on request
`timescale 1ns/10ps
module kde_operator
  import kde_pkg::*;
(
  // clock
  input wire logic clock_in,
  // keys toward the editor
  output kde_pkg::kde_keys_t keys_out
);
  initial keys_out = '0;
  // release long enough that the debouncer sees every press end
  task automatic press(input kde_keys_t k, input int hold);
    @(posedge clock_in);
    keys_out <= k;
    repeat (hold) @(posedge clock_in);
    keys_out <= '0;
    repeat (10) @(posedge clock_in);
  endtask
endmodule

// file: testbench/tb_kde_editor.sv
// self-checking bench for the keypad digit entry editor
`timescale 1ns/10ps
module tb_kde_editor;
  import kde_pkg::*;
  localparam int ERR = 4;
  localparam int LIM = 6;
  localparam kde_keys_t K_UP = 4'h8;
  localparam kde_keys_t K_DN = 4'h4;
  localparam kde_keys_t K_MODE = 4'h2;
  localparam kde_keys_t K_ENT = 4'h1;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic edit_active_in = 1'b1;
  logic load_in = 1'b0;
  kde_param_t param_in = '0;
  kde_keys_t keys;
  logic commit_out;
  kde_val_t commit_value_out;
  logic nav_up_out;
  logic nav_down_out;
  logic mode_short_out;
  logic cursor_mode_out;
  logic error_out;
  kde_disp_t disp_out;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int ncommit = 0;
  int nnav = 0;
  int nnavd = 0;
  int nshort = 0;
  int err_run = 0;
  int err_len = 0;

  always #2 clock_in = ~clock_in;

  kde_operator op (.clock_in(clock_in), .keys_out(keys));

  // short counts keep the run small
  kde_editor #(.HOLD_CNT(8), .LIMIT_CNT(LIM), .ERR_CNT(ERR), .DEBOUNCE_CNT(2)) dut (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .keys_in(keys),
    .edit_active_in(edit_active_in),
    .load_in(load_in),
    .param_in(param_in),
    .commit_out(commit_out),
    .commit_value_out(commit_value_out),
    .nav_up_out(nav_up_out),
    .nav_down_out(nav_down_out),
    .mode_short_out(mode_short_out),
    .cursor_mode_out(cursor_mode_out),
    .error_out(error_out),
    .disp_out(disp_out)
  );

  // ==========
  // checks and report
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check_val(input kde_val_t got, input kde_val_t exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t value %0d not %0d", $time, got, exp);
    end
  endtask

  task automatic check_vec(input logic [5:0] got, input logic [5:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t flags %b not %b", $time, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      fail_count++;
      $display("MISMATCH %0t count %0d not %0d", $time, got, exp);
    end
  endtask

  always @(posedge clock_in)
  begin
    cycles <= cycles + 1;
    if (commit_out === 1'b1)
      ncommit <= ncommit + 1;
    if (nav_up_out === 1'b1)
      nnav <= nnav + 1;
    if (nav_down_out === 1'b1)
      nnavd <= nnavd + 1;
    if (mode_short_out === 1'b1)
      nshort <= nshort + 1;
    if (error_out === 1'b1)
      err_run <= err_run + 1;
    else if (err_run > 0)
    begin
      err_len <= err_run;
      err_run <= 0;
    end
    if (cycles == 6000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  // ==========
  // shared steps
  task automatic load(input kde_val_t v, lo, hi, input logic sgn, input logic [1:0] dec);
    @(posedge clock_in);
    param_in <= '{v, lo, hi, sgn, dec};
    load_in <= 1'b1;
    @(posedge clock_in);
    load_in <= 1'b0;
    repeat (2) @(posedge clock_in);
  endtask

  task automatic enter_ok(input kde_val_t exp);
    int n;
    n = ncommit;
    op.press(K_ENT, 4);
    check_cnt(ncommit, n + 1);
    check_val(commit_value_out, exp);
  endtask

  task automatic enter_bad();
    int n;
    n = ncommit;
    err_len = 0;
    op.press(K_ENT, 4);
    for (int i = 0; i < 40 && error_out !== 1'b0; i++)
      @(posedge clock_in);
    @(posedge clock_in);
    check_cnt(err_len, ERR + LIM);
    check_cnt(ncommit, n);
  endtask

  // ==========
  // scenarios
  task automatic t_whole();
    load(6000, 0, 59900, 1'b0, 2'h2);
    check_val(kde_val_t'(disp_out.seg[0]), 18'h0_003f);
    check_val(kde_val_t'(disp_out.seg[5]), 18'h0_0000);
    op.press(K_UP, 4);
    enter_ok(6001);
    op.press(K_DN, 4);
    op.press(K_DN, 4);
    enter_ok(5999);
  endtask

  task automatic t_two_dec();
    load(-10000, -10000, 10000, 1'b1, 2'h2);
    check_vec(disp_out.dp, 6'h02);
    op.press(K_UP, 4);
    check_vec(disp_out.dp, 6'h04);
    enter_ok(-9999);
  endtask

  task automatic t_cursor();
    load(6009, 0, 59900, 1'b0, 2'h2);
    op.press(K_MODE, 20);
    check_vec({5'h00, cursor_mode_out}, 6'h01);
    check_vec(disp_out.blink, 6'h01);
    op.press(K_UP, 4);
    enter_ok(6000);
    check_vec({5'h00, cursor_mode_out}, 6'h01);
    op.press(K_DN, 4);
    check_vec(disp_out.blink, 6'h02);
  endtask

  task automatic t_reject();
    load(59900, 0, 59900, 1'b0, 2'h2);
    op.press(K_DN, 4);
    op.press(K_UP, 4);
    enter_bad();
    check_vec(disp_out.blink, 6'h01);
    enter_ok(59900);
    load(-1000, -1000, 1000, 1'b1, 2'h1);
    op.press(K_UP, 4);
    enter_bad();
    enter_ok(-1000);
    load(1000, -1000, 1000, 1'b1, 2'h1);
    op.press(K_UP, 4);
    enter_bad();
    enter_ok(1000);
  endtask

  task automatic t_minus();
    int n;
    load(5, -1000, 1000, 1'b1, 2'h1);
    repeat (4) op.press(K_DN, 4);
    check_vec(disp_out.blink, 6'h10);
    op.press(K_UP, 4);
    enter_ok(-5);
    op.press(K_MODE, 20);
    check_vec({5'h00, cursor_mode_out}, 6'h00);
    check_vec(disp_out.blink, 6'h00);
    // a short press must not toggle, only report itself
    n = nshort;
    op.press(K_MODE, 4);
    check_vec({5'h00, cursor_mode_out}, 6'h00);
    check_cnt(nshort, n + 1);
  endtask

  task automatic t_nav();
    int n;
    n = nnav;
    edit_active_in <= 1'b0;
    op.press(K_UP, 1);
    check_cnt(nnav, n);
    op.press(K_UP, 40);
    check_cnt(nnav, n + 1);
    n = nnavd;
    op.press(K_DN, 4);
    check_cnt(nnavd, n + 1);
    edit_active_in <= 1'b1;
  endtask

  initial
  begin
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    t_whole();
    t_two_dec();
    t_cursor();
    t_reject();
    t_minus();
    t_nav();
    report_and_stop();
  end
endmodule
